// >>> rtl/alz_top.sv
// Ambient light sensing, averaging, zone classification and bank targets.
// Assumes the sensor front end delivers each input as an 8-bit code from
// outside the clock domain; configuration ports are on the same clock.
`timescale 1ns/1ps

// Behaviour
// - In sensing mode each bank with als_mode set follows the measured light; the others keep a fixed pick.
// - Five-bit resistor select per input; code zero makes that input high impedance.
// - Each resistor code step adds 54 uA of allowed sensor current.
// - Sensing disabled forces both inputs high impedance whatever the resistor code.
// - Four shared boundaries split the light scale into five zones.
// - Each bank has five zone targets; in als_mode the current zone picks the target, otherwise manual_sel does.
// - Boundaries are 8-bit codes on the converter scale.
// - Each boundary has high and low thresholds giving hysteresis.
// - Five per-bank bits enable the PWM input per zone.
// - Two-bit select picks average, maximum, input one or input two.
// - Inputs are combined before conversion.
// - Enabling sensing starts continuous conversion.
// - Conversions run at a fixed rate, one fixed interval each.
// - Converter readback refreshes after every conversion while sensing.
// - Eight selectable averaging periods.
// - Averager output is the mean of all samples in the period.
// - Averaged result is readable.
// - Start-up begins in zone zero with short fast averaging periods.
// - Lowest PWM enable bit belongs to zone zero, upward from there.
module alz_top #(
  parameter int CONV_CYCLES = alz_pkg::CONV_CYC
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire alz_pkg::alz_cfg_s CFG_I,
  input wire alz_pkg::alz_bound_s [3:0] BOUND_I,
  input wire alz_pkg::alz_bank_cfg_s [2:0] BANK_CFG_I,
  input wire logic [7:0] LIGHT_INPUT_ONE_I,
  input wire logic [7:0] LIGHT_INPUT_TWO_I,
  output logic LIGHT_ONE_HIZ_O,
  output logic LIGHT_TWO_HIZ_O,
  output logic [10:0] LIGHT_ONE_CUR_UA_O,
  output logic [10:0] LIGHT_TWO_CUR_UA_O,
  output logic [7:0] ADC_CODE_O,
  output logic CONV_DONE_O,
  output logic [7:0] AVG_CODE_O,
  output logic AVG_DONE_O,
  output logic FAST_START_O,
  output logic [2:0] ZONE_O,
  output logic [2:0][7:0] BANK_TARGET_O,
  output logic [2:0] BANK_PWM_EN_O
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [7:0] one_s1_r;
  logic [7:0] one_s2_r;
  logic [7:0] two_s1_r;
  logic [7:0] two_s2_r;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      one_s1_r <= 8'h00;
      one_s2_r <= 8'h00;
      two_s1_r <= 8'h00;
      two_s2_r <= 8'h00;
    end else begin
      one_s1_r <= LIGHT_INPUT_ONE_I;
      one_s2_r <= one_s1_r;
      two_s1_r <= LIGHT_INPUT_TWO_I;
      two_s2_r <= two_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Sensor pin control
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      LIGHT_ONE_HIZ_O <= 1'b1;
      LIGHT_TWO_HIZ_O <= 1'b1;
      LIGHT_ONE_CUR_UA_O <= 11'h000;
      LIGHT_TWO_CUR_UA_O <= 11'h000;
    end else begin
      LIGHT_ONE_HIZ_O <= !CFG_I.sense_en || CFG_I.res_sel_one == alz_pkg::RES_HIZ_CODE;
      LIGHT_TWO_HIZ_O <= !CFG_I.sense_en || CFG_I.res_sel_two == alz_pkg::RES_HIZ_CODE;
      LIGHT_ONE_CUR_UA_O <= 11'(CFG_I.res_sel_one * alz_pkg::CUR_STEP_UA);
      LIGHT_TWO_CUR_UA_O <= 11'(CFG_I.res_sel_two * alz_pkg::CUR_STEP_UA);
    end
  end

  // ----------------------------------------------------------------
  // Input select stage, ahead of the converter
  // ----------------------------------------------------------------
  logic [8:0] pair_sum;
  logic [7:0] mix_code;

  always_comb begin
    pair_sum = {1'b0, one_s2_r} + {1'b0, two_s2_r};
    case (CFG_I.input_sel)
      alz_pkg::SEL_AVG: mix_code = pair_sum[8:1];
      alz_pkg::SEL_MAX: mix_code = (one_s2_r > two_s2_r) ? one_s2_r : two_s2_r;
      alz_pkg::SEL_ONE: mix_code = one_s2_r;
      default: mix_code = two_s2_r;
    endcase
  end

  // ----------------------------------------------------------------
  // Converter timebase and readback
  // ----------------------------------------------------------------
  localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);
  logic [15:0] conv_cnt_r;
  logic conv_end;

  assign conv_end = CFG_I.sense_en && conv_cnt_r == CONV_LAST;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      conv_cnt_r <= 16'h0000;
    end else if (!CFG_I.sense_en || conv_end) begin
      conv_cnt_r <= 16'h0000;
    end else begin
      conv_cnt_r <= conv_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ADC_CODE_O <= 8'h00;
      CONV_DONE_O <= 1'b0;
    end else begin
      CONV_DONE_O <= conv_end;
      if (conv_end) begin
        ADC_CODE_O <= mix_code;
      end
    end
  end

  // ----------------------------------------------------------------
  // Start-up sequencing
  // ----------------------------------------------------------------
  alz_pkg::alz_state_e st_r;
  logic [1:0] fast_cnt_r;
  logic fast_mode;

  // Fast averaging also covers the first cycle before the state moves
  assign fast_mode = st_r != alz_pkg::ST_RUN;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      st_r <= alz_pkg::ST_IDLE;
      fast_cnt_r <= 2'h0;
    end else if (!CFG_I.sense_en) begin
      st_r <= alz_pkg::ST_IDLE;
      fast_cnt_r <= 2'h0;
    end else begin
      case (st_r)
        alz_pkg::ST_IDLE: begin
          st_r <= alz_pkg::ST_FAST;
        end
        alz_pkg::ST_FAST: begin
          if (AVG_DONE_O) begin
            fast_cnt_r <= fast_cnt_r + 2'h1;
            if (fast_cnt_r == alz_pkg::FAST_PERIODS_LAST) begin
              st_r <= alz_pkg::ST_RUN;
            end
          end
        end
        alz_pkg::ST_RUN: begin
          st_r <= alz_pkg::ST_RUN;
        end
        default: begin
          st_r <= alz_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      FAST_START_O <= 1'b0;
    end else begin
      FAST_START_O <= CFG_I.sense_en && fast_mode;
    end
  end

  // ----------------------------------------------------------------
  // Averager
  // ----------------------------------------------------------------
  // Power-of-two sample counts keep the divide to a shift
  logic [17:0] acc_r;
  logic [9:0] scnt_r;
  logic [3:0] shift;
  logic [9:0] scnt_last;
  logic [17:0] acc_sum;
  logic per_last;

  always_comb begin
    shift = fast_mode ? alz_pkg::FAST_SHIFT : alz_pkg::AVG_BASE_SHIFT + {1'b0, CFG_I.avg_sel};
    scnt_last = 10'((11'h001 << shift) - 11'h001);
    acc_sum = acc_r + {10'h000, mix_code};
    per_last = scnt_r == scnt_last;
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      acc_r <= 18'h0_0000;
      scnt_r <= 10'h000;
      AVG_CODE_O <= 8'h00;
      AVG_DONE_O <= 1'b0;
    end else if (!CFG_I.sense_en) begin
      acc_r <= 18'h0_0000;
      scnt_r <= 10'h000;
      AVG_DONE_O <= 1'b0;
    end else begin
      AVG_DONE_O <= conv_end && per_last;
      if (conv_end && per_last) begin
        AVG_CODE_O <= 8'(acc_sum >> shift);
        acc_r <= 18'h0_0000;
        scnt_r <= 10'h000;
      end else if (conv_end) begin
        acc_r <= acc_sum;
        scnt_r <= scnt_r + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Zone classification with hysteresis
  // ----------------------------------------------------------------
  logic [3:0] above_high;
  logic [3:0] not_below_low;
  logic [2:0] up_cnt;
  logic [2:0] keep_cnt;

  genvar gi;
  generate
    for (gi = 0; gi < alz_pkg::NUM_BOUNDS; gi++) begin : g_bound
      alz_bound_cmp u_cmp (
        .code_i(AVG_CODE_O),
        .bound_i(BOUND_I[gi]),
        .above_high_o(above_high[gi]),
        .not_below_low_o(not_below_low[gi])
      );
    end
  endgenerate

  always_comb begin
    up_cnt = 3'h0;
    keep_cnt = 3'h0;
    for (int i = 0; i < alz_pkg::NUM_BOUNDS; i++) begin
      up_cnt = up_cnt + {2'h0, above_high[i]};
      keep_cnt = keep_cnt + {2'h0, not_below_low[i]};
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ZONE_O <= alz_pkg::ZONE_LOW;
    end else if (!CFG_I.sense_en) begin
      ZONE_O <= alz_pkg::ZONE_LOW;
    end else if (AVG_DONE_O) begin
      if (up_cnt > ZONE_O) begin
        ZONE_O <= up_cnt;
      end else if (keep_cnt < ZONE_O) begin
        ZONE_O <= keep_cnt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control bank targets and PWM enables
  // ----------------------------------------------------------------
  logic [2:0][2:0] bank_idx;

  always_comb begin
    for (int b = 0; b < alz_pkg::NUM_BANKS; b++) begin
      if (BANK_CFG_I[b].als_mode) begin
        bank_idx[b] = ZONE_O;
      end else if (BANK_CFG_I[b].manual_sel[2]) begin
        bank_idx[b] = alz_pkg::ZONE_TOP;
      end else begin
        bank_idx[b] = {1'b0, BANK_CFG_I[b].manual_sel[1:0]};
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      BANK_TARGET_O <= '0;
      BANK_PWM_EN_O <= 3'h0;
    end else begin
      for (int b = 0; b < alz_pkg::NUM_BANKS; b++) begin
        BANK_TARGET_O[b] <= BANK_CFG_I[b].target[bank_idx[b]];
        BANK_PWM_EN_O[b] <= BANK_CFG_I[b].pwm_zone_en[bank_idx[b]];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  logic [15:0] gap_r;
  logic gap_ok_r;

  // Independent spacing counter between conversions
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || !CFG_I.sense_en || conv_end) begin
      gap_r <= 16'h0000;
    end else begin
      gap_r <= gap_r + 16'h0001;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      gap_ok_r <= 1'b0;
    end else begin
      gap_ok_r <= CFG_I.sense_en;
    end
  end

  sequence conv_s;
    conv_end ##1 CONV_DONE_O;
  endsequence

  sequence period_s;
    conv_end && per_last && CFG_I.sense_en ##1 AVG_DONE_O;
  endsequence

  hiz_off_a: assert property (!CFG_I.sense_en |=> LIGHT_ONE_HIZ_O && LIGHT_TWO_HIZ_O)
    else $error("input not high impedance while sensing off");

  hiz_code_a: assert property (CFG_I.res_sel_one == 5'h00 |=> LIGHT_ONE_HIZ_O)
    else $error("zero resistor code did not float input one");

  cur_step_a: assert property (1'b1 |=> LIGHT_TWO_CUR_UA_O == 11'($past(CFG_I.res_sel_two) * 54))
    else $error("allowed current not 54 uA per step");

  conv_rate_a: assert property (conv_end && gap_ok_r |-> gap_r == 16'(CONV_CYCLES - 1))
    else $error("conversion spacing wrong");

  adc_update_a: assert property (conv_end |-> conv_s ##0 ADC_CODE_O == $past(mix_code))
    else $error("readback not refreshed after conversion");

  avg_clear_a: assert property (period_s |-> acc_r == 18'h0_0000 && scnt_r == 10'h000)
    else $error("averager did not clear at period end");

  fast_len_a: assert property (period_s ##0 FAST_START_O |-> $past(scnt_r, 2) == 10'h007)
    else $error("fast period is not eight samples");

  zone_init_a: assert property ($rose(CFG_I.sense_en) |-> ZONE_O == 3'h0)
    else $error("zone not zero at sensing start");

  zone_up_a: assert property (AVG_DONE_O && CFG_I.sense_en && ZONE_O < 3'h4 &&
    AVG_CODE_O > BOUND_I[ZONE_O[1:0]].high |=> ZONE_O > $past(ZONE_O))
    else $error("zone did not rise above high threshold");

  zone_hold_a: assert property (AVG_DONE_O && CFG_I.sense_en && ZONE_O > 3'h0 && ZONE_O < 3'h4 &&
    AVG_CODE_O >= BOUND_I[2'(ZONE_O - 3'h1)].low && AVG_CODE_O <= BOUND_I[ZONE_O[1:0]].high
    |=> ZONE_O == $past(ZONE_O))
    else $error("zone moved inside the hysteresis band");

  bank_als_a: assert property (BANK_CFG_I[0].als_mode |=> BANK_TARGET_O[0] ==
    $past(BANK_CFG_I[0].target[ZONE_O]))
    else $error("bank target not taken from zone");

  pwm_zone_a: assert property (BANK_CFG_I[2].als_mode |=> BANK_PWM_EN_O[2] ==
    $past(BANK_CFG_I[2].pwm_zone_en[ZONE_O]))
    else $error("pwm enable not taken from zone bit");

  max_sel_a: assert property (conv_end && CFG_I.input_sel == alz_pkg::SEL_MAX |=>
    ADC_CODE_O >= $past(one_s2_r) && ADC_CODE_O >= $past(two_s2_r))
    else $error("maximum select below an input");

endmodule

// >>> rtl/alz_pkg.sv
// Shared constants and carrier types for the ambient light zone controller.
// Assumes one 125 MHz clock; all configuration arrives on plain ports.
package alz_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int CONV_TIME_NS = 140000;
  localparam int CONV_CYC = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int CONV_CNT_W = 16;
  localparam int FAST_TIME_NS = 1100000;
  // Fast start-up period rounded up to a whole number of samples
  localparam int FAST_SAMPLES = (FAST_TIME_NS + CONV_TIME_NS - 1) / CONV_TIME_NS;
  localparam logic [3:0] FAST_SHIFT = 4'h3;
  localparam logic [1:0] FAST_PERIODS_LAST = 2'h2;
  // Normal periods hold 2^(sel+3) samples: 8 up to 1024
  localparam logic [3:0] AVG_BASE_SHIFT = 4'h3;

  // ----------------------------------------------------------------
  // Widths and fields
  // ----------------------------------------------------------------
  localparam int CODE_W = 8;
  localparam int ACC_W = 18;
  localparam int SCNT_W = 10;
  localparam int CUR_W = 11;
  localparam int NUM_ZONES = 5;
  localparam int NUM_BOUNDS = 4;
  localparam int NUM_BANKS = 3;
  localparam logic [CUR_W-1:0] CUR_STEP_UA = 11'h036;
  localparam logic [4:0] RES_HIZ_CODE = 5'h00;
  localparam logic [2:0] ZONE_LOW = 3'h0;
  localparam logic [2:0] ZONE_TOP = 3'h4;

  typedef enum logic [1:0] {
    SEL_AVG = 2'h0,
    SEL_MAX = 2'h1,
    SEL_ONE = 2'h2,
    SEL_TWO = 2'h3
  } alz_insel_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_FAST = 2'h1,
    ST_RUN = 2'h3
  } alz_state_e;

  typedef struct packed {
    logic sense_en;
    alz_insel_e input_sel;
    logic [2:0] avg_sel;
    logic [4:0] res_sel_one;
    logic [4:0] res_sel_two;
  } alz_cfg_s;

  typedef struct packed {
    logic [CODE_W-1:0] high;
    logic [CODE_W-1:0] low;
  } alz_bound_s;

  typedef struct packed {
    logic als_mode;
    logic [2:0] manual_sel;
    logic [NUM_ZONES-1:0] pwm_zone_en;
    logic [NUM_ZONES-1:0][CODE_W-1:0] target;
  } alz_bank_cfg_s;

endpackage

// >>> rtl/alz_bound_cmp.sv
// One zone boundary comparator: upper threshold and lower threshold.
// Assumes the averaged code and thresholds share one 8-bit scale.
`timescale 1ns/1ps
module alz_bound_cmp (
  input wire logic [7:0] code_i,
  input wire alz_pkg::alz_bound_s bound_i,
  output logic above_high_o,
  output logic not_below_low_o
);

  // Strictly above high moves up; strictly below low moves down
  assign above_high_o = code_i > bound_i.high;
  assign not_below_low_o = code_i >= bound_i.low;

endmodule

// >>> tb/alz_sensor_model.sv
// Partner model: the two light sensors seen as 8-bit codes.
// Assumes the bench sets the light levels; the block's pin states steer it.
`timescale 1ns/1ps
module alz_sensor_model (
  input wire logic clk_i,
  input wire logic hiz_one_i,
  input wire logic hiz_two_i,
  input wire logic [7:0] lvl_one_i,
  input wire logic [7:0] lvl_two_i,
  output logic [7:0] code_one_o,
  output logic [7:0] code_two_o
);
  // --------------------------------------------------------------
  // Released inputs
  // --------------------------------------------------------------
  // A floating input wanders, so a stale level never passes for a sample
  logic [7:0] junk_r = 8'h00;
  always_ff @(posedge clk_i) begin
    junk_r <= ~junk_r ^ 8'h5a;
  end
  assign code_one_o = hiz_one_i ? (~lvl_one_i ^ junk_r) : lvl_one_i;
  assign code_two_o = hiz_two_i ? (~lvl_two_i ^ junk_r) : lvl_two_i;
endmodule

// >>> tb/alz_top_tb.sv
// Self-checking bench for the ambient light zone controller.
// Assumes a shortened conversion count; sensors come from the partner model.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module alz_top_tb;
  localparam int CC = 20;
  logic clk;
  logic rst_n;
  alz_pkg::alz_cfg_s cfg;
  alz_pkg::alz_bound_s [3:0] bnd;
  alz_pkg::alz_bank_cfg_s [2:0] bank;
  logic [7:0] lvl1, lvl2, in1, in2, adc, avg;
  logic hiz1, hiz2, cdone, adone, fast;
  logic [10:0] cur1, cur2;
  logic [2:0] zone, pwm;
  logic [2:0][7:0] tgt;
  int err_count = 0;
  int compares = 0;

  alz_sensor_model sensors (.clk_i(clk), .hiz_one_i(hiz1), .hiz_two_i(hiz2),
    .lvl_one_i(lvl1), .lvl_two_i(lvl2), .code_one_o(in1), .code_two_o(in2));

  alz_top #(.CONV_CYCLES(CC)) DUT (.CLK_I(clk), .RST_N_I(rst_n), .CFG_I(cfg),
    .BOUND_I(bnd), .BANK_CFG_I(bank), .LIGHT_INPUT_ONE_I(in1), .LIGHT_INPUT_TWO_I(in2),
    .LIGHT_ONE_HIZ_O(hiz1), .LIGHT_TWO_HIZ_O(hiz2), .LIGHT_ONE_CUR_UA_O(cur1),
    .LIGHT_TWO_CUR_UA_O(cur2), .ADC_CODE_O(adc), .CONV_DONE_O(cdone), .AVG_CODE_O(avg),
    .AVG_DONE_O(adone), .FAST_START_O(fast), .ZONE_O(zone), .BANK_TARGET_O(tgt),
    .BANK_PWM_EN_O(pwm));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_conv(output int c);
    c = 0;
    do begin tick(1); c++; end while (cdone !== 1'b1 && c < 200);
    `CHK("conv_done", 1'b1, cdone)
  endtask

  task automatic wait_avg();
    int c;
    c = 0;
    do begin tick(1); c++; end while (adone !== 1'b1 && c < 400);
    `CHK("avg_done", 1'b1, adone)
  endtask

  task automatic final_report();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic test_reset();
    `CHK("hiz_one_rst", 1'b1, hiz1)
    `CHK("zone_rst", 3'h0, zone)
    @(posedge clk);
    cfg.res_sel_two <= 5'h1f;
    tick(2);
    `CHK("hiz_two_off", 1'b1, hiz2)
    `CHK("cur_two", 11'h68a, cur2)
    `CHK("cur_one", 11'h000, cur1)
    @(posedge clk);
    cfg.sense_en <= 1'b1;
    tick(2);
    `CHK("hiz_one_code0", 1'b1, hiz1)
    `CHK("hiz_two_on", 1'b0, hiz2)
    @(posedge clk);
    cfg.sense_en <= 1'b0;
    cfg.res_sel_one <= 5'h01;
    tick(2);
    `CHK("hiz_one_off", 1'b1, hiz1)
    `CHK("cur_one_step", 11'h036, cur1)
    $display("test_reset done");
  endtask

  task automatic test_conv();
    logic [7:0] exp_c [4];
    int c;
    // Odd sum checks that the average mode rounds down
    exp_c = '{8'h96, 8'hc9, 8'h64, 8'hc9};
    @(posedge clk);
    lvl1 <= 8'h64;
    lvl2 <= 8'hc9;
    cfg.sense_en <= 1'b1;
    wait_conv(c);
    `CHK("first_conv", 1'b1, (c >= CC && c <= CC + 2))
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      cfg.input_sel <= alz_pkg::alz_insel_e'(s);
      wait_conv(c);
      wait_conv(c);
      `CHK("conv_spacing", CC, c)
      `CHK("adc_code", exp_c[s], adc)
    end
    @(posedge clk);
    cfg.sense_en <= 1'b0;
    c = 0;
    repeat (3 * CC) begin tick(1); if (cdone === 1'b1) c++; end
    `CHK("done_while_off", 0, c)
    $display("test_conv done");
  endtask

  task automatic test_avg();
    int c, n, sum;
    logic got;
    logic [7:0] v;
    v = 8'h10;
    @(posedge clk);
    cfg.avg_sel <= 3'h1;
    cfg.input_sel <= alz_pkg::SEL_ONE;
    cfg.sense_en <= 1'b1;
    lvl1 <= v;
    tick(2);
    `CHK("fast_start", 1'b1, fast)
    for (int p = 0; p < 4; p++) begin
      n = 0;
      sum = 0;
      got = 1'b0;
      // A ramp makes every sample distinct, so a missed or extra one shows
      while (!got && n < 40) begin
        wait_conv(c);
        sum += v;
        n++;
        got = (adone === 1'b1);
        repeat (2) if (!got) begin tick(1); got = (adone === 1'b1); end
        @(posedge clk);
        v = v + 8'h03;
        lvl1 <= v;
      end
      `CHK("avg_samples", (p < 3) ? 8 : 16, n)
      `CHK("avg_code", 8'(sum / n), avg)
    end
    `CHK("fast_end", 1'b0, fast)
    @(posedge clk);
    cfg.sense_en <= 1'b0;
    tick(2);
    $display("test_avg done");
  endtask

  task automatic test_zone();
    logic [7:0] lv [6];
    logic [2:0] ez [6];
    int mi;
    lv = '{8'h90, 8'h80, 8'h70, 8'h80, 8'hff, 8'h00};
    ez = '{3'h2, 3'h2, 3'h1, 3'h1, 3'h4, 3'h0};
    `CHK("zone_off", 3'h0, zone)
    @(posedge clk);
    cfg.avg_sel <= 3'h0;
    cfg.sense_en <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      lvl1 <= lv[i];
      // First period may mix two levels; the second is clean
      wait_avg();
      wait_avg();
      tick(3);
      `CHK("zone", ez[i], zone)
      for (int b = 0; b < 3; b += 2) begin
        `CHK("bank_target", bank[b].target[ez[i]], tgt[b])
        `CHK("bank_pwm", bank[b].pwm_zone_en[ez[i]], pwm[b])
      end
    end
    for (int m = 0; m < 8; m++) begin
      @(posedge clk);
      bank[1].manual_sel <= 3'(m);
      tick(2);
      mi = (m > 3) ? 4 : m;
      `CHK("manual_target", bank[1].target[mi], tgt[1])
      `CHK("manual_pwm", bank[1].pwm_zone_en[mi], pwm[1])
    end
    $display("test_zone done");
  endtask

  task automatic test_long();
    int c;
    @(posedge clk);
    cfg.sense_en <= 1'b0;
    cfg.avg_sel <= 3'h7;
    lvl1 <= 8'hff;
    tick(2);
    @(posedge clk);
    cfg.sense_en <= 1'b1;
    // Three fast periods first, then the longest normal period at full scale
    repeat (3) wait_avg();
    c = 0;
    do begin tick(1); c++; end while (adone !== 1'b1 && c < 1100 * CC);
    `CHK("long_period", 1024 * CC, c)
    `CHK("long_avg", 8'hff, avg)
    $display("test_long done");
  endtask

  // --------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    cfg = '0;
    lvl1 = 8'h00;
    lvl2 = 8'h00;
    bnd = {8'hf0, 8'he0, 8'hc8, 8'hb8, 8'h88, 8'h78, 8'h48, 8'h38};
    for (int b = 0; b < 3; b++) begin
      bank[b].als_mode = (b != 1);
      bank[b].manual_sel = 3'h0;
      for (int z = 0; z < 5; z++) bank[b].target[z] = 8'(8'h10 * (b + 1) + z);
    end
    bank[0].pwm_zone_en = 5'h15;
    bank[1].pwm_zone_en = 5'h0b;
    bank[2].pwm_zone_en = 5'h06;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    tick(3);
    test_reset();
    test_conv();
    test_avg();
    test_zone();
    test_long();
    final_report();
  end

  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    $display("[ERR] watchdog exp done got timeout");
    final_report();
  end
endmodule
